// ===== pkg/clkstop_pkg.sv
// constants for the processor clock stop sequencer
// Operation
// RULE1 - host keeps every bus master away from the processor and its memory first
// RULE2 - host polls masters for write completion or waits before disabling
// RULE3 - processor has its power-down interrupt and routine ready beforehand
// RULE4 - host writes 0x02 into module control bits 2:0 to request disable
// RULE5 - a disable request written to module control raises the power-down interrupt
// RULE6 - writing 0x01 into transition command bits 1:0 starts the transition
// RULE7 - transition status bits 1:0 stay nonzero during transition, zero when done
// RULE8 - module status bits 5:0 read 0x02 once the clock stop completes
// RULE9 - processor confirms its own bus masters finished all transfers
// RULE10 - processor enables a host-to-processor interrupt or NMI as wake source
// RULE11 - processor writes 0x0001_5555 to its power-down command register
// RULE12 - processor sets override bit 0 of global power control
// RULE13 - processor executes idle as the last step of its routine
// RULE14 - host clears override only after shutdown is reported complete
// RULE15 - clock stays running until idle seen with override set during transition
package clkstop_pkg;
  localparam logic [31:0] GLOBAL_POWER_CONTROL_ADDR = 32'h01C4_1000;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h01C4_1010;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h01C4_1014;
  localparam logic [31:0] POWER_TRANSITION_COMMAND_ADDR = 32'h01C4_1120;
  localparam logic [31:0] POWER_TRANSITION_STATUS_ADDR = 32'h01C4_1128;
  localparam logic [31:0] MODULE_STATUS_ADDR = 32'h01C4_1800;
  localparam logic [31:0] MODULE_CONTROL_ADDR = 32'h01C4_1A00;
  localparam logic [31:0] PROCESSOR_POWERDOWN_COMMAND_ADDR = 32'h01C4_1B00;
  localparam int OVERRIDE_BIT = 0;
  localparam int NEXT_LSB = 0;
  localparam int NEXT_W = 3;
  localparam int GO_LSB = 0;
  localparam int GO_W = 2;
  localparam int PEND_W = 2;
  localparam int STATE_W = 6;
  localparam int IRQ_W = 2;
  localparam int IRQ_POWERDOWN_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam logic [2:0] NEXT_DISABLE = 3'h2;
  localparam logic [2:0] NEXT_ENABLE = 3'h3;
  localparam logic [2:0] NEXT_RESET = 3'h3;
  localparam logic [1:0] GO_START = 2'h1;
  localparam logic [1:0] PEND_BUSY = 2'h1;
  localparam logic [1:0] PEND_IDLE = 2'h0;
  localparam logic [5:0] STATE_DISABLED = 6'h02;
  localparam logic [5:0] STATE_ENABLED = 6'h03;
  localparam logic [31:0] POWERDOWN_COMMAND_RESET = 32'h0000_0000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== core/pin_sync3.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;
  logic next_q;

  // only s2 reads s1; q moves once s2 and s3 agree
  always_comb begin
    next_q = (s2 == s3) ? s3 : q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule

// ===== core/dsp_clock_stop_sequencer.sv
// processor clock stop sequencer with axi4-lite register slave
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module dsp_clock_stop_sequencer (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic PROC_IDLE,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic PROC_CLK_EN,
  output logic INTERRUPT
);
  typedef enum logic [1:0] {ST_ON, ST_GO_OFF, ST_OFF, ST_GO_ON} seq_state_t;

  localparam logic [31:0] GLOBAL_POWER_CONTROL_ADDR_W = clkstop_pkg::GLOBAL_POWER_CONTROL_ADDR;
  localparam logic [31:0] IRQ_STATUS_ADDR_W = clkstop_pkg::IRQ_STATUS_ADDR;
  localparam logic [31:0] IRQ_MASK_ADDR_W = clkstop_pkg::IRQ_MASK_ADDR;
  localparam logic [31:0] POWER_TRANSITION_COMMAND_ADDR_W = clkstop_pkg::POWER_TRANSITION_COMMAND_ADDR;
  localparam logic [31:0] POWER_TRANSITION_STATUS_ADDR_W = clkstop_pkg::POWER_TRANSITION_STATUS_ADDR;
  localparam logic [31:0] MODULE_STATUS_ADDR_W = clkstop_pkg::MODULE_STATUS_ADDR;
  localparam logic [31:0] MODULE_CONTROL_ADDR_W = clkstop_pkg::MODULE_CONTROL_ADDR;
  localparam logic [31:0] PROCESSOR_POWERDOWN_COMMAND_ADDR_W = clkstop_pkg::PROCESSOR_POWERDOWN_COMMAND_ADDR;

  seq_state_t fsm;
  seq_state_t next_fsm;
  logic idle_q;
  logic aw_have, next_aw_have;
  logic w_have, next_w_have;
  logic [31:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [2:0] mod_next, next_mod_next;
  logic override, next_override;
  logic [31:0] pwrdn_cmd, next_pwrdn_cmd;
  logic [1:0] irq_stat, next_irq_stat;
  logic [1:0] irq_mask, next_irq_mask;
  logic [1:0] pending, next_pending;
  logic [5:0] mod_state, next_mod_state;
  logic next_clk_en, next_interrupt;
  logic wr_do, rd_do, wr_hit, rd_hit;
  logic [31:0] wr_val, rd_val;
  logic [1:0] irq_set;

  // idle comes from the processor domain, so it is filtered
  pin_sync3 idle_sync (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .ce(CE),
    .d(PROC_IDLE),
    .q(idle_q)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nv[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = S_AXI_BVALID;
    next_bresp = S_AXI_BRESP;
    next_rvalid = S_AXI_RVALID;
    next_rresp = S_AXI_RRESP;
    next_rdata = S_AXI_RDATA;
    next_mod_next = mod_next;
    next_override = override;
    next_pwrdn_cmd = pwrdn_cmd;
    next_irq_mask = irq_mask;
    next_pending = pending;
    next_mod_state = mod_state;
    next_fsm = fsm;
    next_clk_en = PROC_CLK_EN;
    irq_set = 2'h0;
    wr_hit = 1'b1;
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;

    // either order of address and data; response only when both held
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_have = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_have = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
    end
    wr_do = aw_have && w_have && !S_AXI_BVALID;
    wr_val = 32'h0000_0000;
    if (wr_do) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      unique case ({aw_addr[31:2], 2'b00})
        GLOBAL_POWER_CONTROL_ADDR_W: begin
          wr_val = merge({31'h0, override}, w_data, w_strb);
          next_override = wr_val[clkstop_pkg::OVERRIDE_BIT];
        end
        IRQ_MASK_ADDR_W: begin
          wr_val = merge({30'h0, irq_mask}, w_data, w_strb);
          next_irq_mask = wr_val[clkstop_pkg::IRQ_W-1:0];
        end
        IRQ_STATUS_ADDR_W: begin
          wr_val = merge(32'h0000_0000, w_data, w_strb);
        end
        MODULE_CONTROL_ADDR_W: begin
          wr_val = merge({29'h0, mod_next}, w_data, w_strb);
          next_mod_next = wr_val[clkstop_pkg::NEXT_LSB +: clkstop_pkg::NEXT_W];
          // disable request interrupts the processor at once [RULE5]
          if (next_mod_next == clkstop_pkg::NEXT_DISABLE) begin
            irq_set[clkstop_pkg::IRQ_POWERDOWN_BIT] = 1'b1;
          end
        end
        POWER_TRANSITION_COMMAND_ADDR_W: begin
          wr_val = merge(32'h0000_0000, w_data, w_strb);
          // a go while a transition runs is ignored [RULE6]
          if (wr_val[clkstop_pkg::GO_LSB +: clkstop_pkg::GO_W] == clkstop_pkg::GO_START) begin
            if (fsm == ST_ON && mod_next == clkstop_pkg::NEXT_DISABLE) begin
              next_fsm = ST_GO_OFF;
              next_pending = clkstop_pkg::PEND_BUSY; // [RULE7]
            end else if (fsm == ST_OFF && mod_next == clkstop_pkg::NEXT_ENABLE) begin
              next_fsm = ST_GO_ON;
              next_pending = clkstop_pkg::PEND_BUSY; // [RULE7]
            end
          end
        end
        PROCESSOR_POWERDOWN_COMMAND_ADDR_W: begin
          next_pwrdn_cmd = merge(pwrdn_cmd, w_data, w_strb);
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
      next_bresp = wr_hit ? clkstop_pkg::RESP_OKAY : clkstop_pkg::RESP_SLVERR;
    end
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end

    rd_do = S_AXI_ARVALID && S_AXI_ARREADY;
    if (rd_do) begin
      unique case ({S_AXI_ARADDR[31:2], 2'b00})
        GLOBAL_POWER_CONTROL_ADDR_W: rd_val = {31'h0, override};
        IRQ_STATUS_ADDR_W: rd_val = {30'h0, irq_stat};
        IRQ_MASK_ADDR_W: rd_val = {30'h0, irq_mask};
        POWER_TRANSITION_COMMAND_ADDR_W: rd_val = 32'h0000_0000;
        POWER_TRANSITION_STATUS_ADDR_W: rd_val = {30'h0, pending};
        MODULE_STATUS_ADDR_W: rd_val = {26'h0, mod_state};
        MODULE_CONTROL_ADDR_W: rd_val = {29'h0, mod_next};
        PROCESSOR_POWERDOWN_COMMAND_ADDR_W: rd_val = pwrdn_cmd;
        default: rd_hit = 1'b0;
      endcase
      next_rvalid = 1'b1;
      next_rdata = rd_val;
      next_rresp = rd_hit ? clkstop_pkg::RESP_OKAY : clkstop_pkg::RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end

    // gating waits for idle under override; a software write alone never stops the clock
    unique case (fsm)
      ST_ON: begin
      end
      ST_GO_OFF: begin
        if (idle_q && override) begin // [RULE15]
          next_fsm = ST_OFF;
          next_clk_en = 1'b0;
          next_pending = clkstop_pkg::PEND_IDLE; // [RULE7]
          next_mod_state = clkstop_pkg::STATE_DISABLED; // [RULE8]
          irq_set[clkstop_pkg::IRQ_DONE_BIT] = 1'b1;
        end
      end
      ST_OFF: begin
      end
      ST_GO_ON: begin
        next_fsm = ST_ON;
        next_clk_en = 1'b1;
        next_pending = clkstop_pkg::PEND_IDLE; // [RULE7]
        next_mod_state = clkstop_pkg::STATE_ENABLED;
        irq_set[clkstop_pkg::IRQ_DONE_BIT] = 1'b1;
      end
    endcase

    // a new event beats a write-one clear in the same cycle
    next_irq_stat = irq_stat;
    if (wr_do && {aw_addr[31:2], 2'b00} == IRQ_STATUS_ADDR_W) begin
      next_irq_stat = irq_stat & ~wr_val[clkstop_pkg::IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | irq_set;
    next_interrupt = |(next_irq_stat & next_irq_mask);
    next_awready = !next_aw_have && !next_bvalid;
    next_wready = !next_w_have && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP <= 2'h0;
      S_AXI_RDATA <= 32'h0000_0000;
      mod_next <= clkstop_pkg::NEXT_RESET;
      override <= 1'b0;
      pwrdn_cmd <= clkstop_pkg::POWERDOWN_COMMAND_RESET;
      irq_stat <= 2'h0;
      irq_mask <= clkstop_pkg::IRQ_MASK_RESET;
      pending <= clkstop_pkg::PEND_IDLE;
      mod_state <= clkstop_pkg::STATE_ENABLED;
      fsm <= ST_ON;
      PROC_CLK_EN <= 1'b1;
      INTERRUPT <= 1'b0;
    end else if (CE) begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      S_AXI_AWREADY <= next_awready;
      S_AXI_WREADY <= next_wready;
      S_AXI_BVALID <= next_bvalid;
      S_AXI_BRESP <= next_bresp;
      S_AXI_ARREADY <= next_arready;
      S_AXI_RVALID <= next_rvalid;
      S_AXI_RRESP <= next_rresp;
      S_AXI_RDATA <= next_rdata;
      mod_next <= next_mod_next;
      override <= next_override;
      pwrdn_cmd <= next_pwrdn_cmd;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      pending <= next_pending;
      mod_state <= next_mod_state;
      fsm <= next_fsm;
      PROC_CLK_EN <= next_clk_en;
      INTERRUPT <= next_interrupt;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  logic mod_dis_wr;
  logic go_off_wr;
  assign mod_dis_wr = CE && wr_do && {aw_addr[31:2], 2'b00} == MODULE_CONTROL_ADDR_W
    && next_mod_next == clkstop_pkg::NEXT_DISABLE;
  assign go_off_wr = CE && wr_do && {aw_addr[31:2], 2'b00} == POWER_TRANSITION_COMMAND_ADDR_W
    && wr_val[1:0] == clkstop_pkg::GO_START && fsm == ST_ON && mod_next == clkstop_pkg::NEXT_DISABLE;

  sequence gate_cause_s;
    fsm == ST_GO_OFF && idle_q && override && CE;
  endsequence
  sequence gate_done_s;
    !PROC_CLK_EN && pending == 2'h0 && mod_state == 6'h02;
  endsequence

  powerdown_irq_a: assert property (mod_dis_wr |=> irq_stat[0] && PROC_CLK_EN) // [RULE5]
    else $error("power-down interrupt not raised after disable request");
  go_starts_a: assert property (go_off_wr |=> fsm == ST_GO_OFF && pending == 2'h1) // [RULE6]
    else $error("go did not start the transition");
  pending_held_a: assert property (fsm == ST_GO_OFF || fsm == ST_GO_ON |-> pending != 2'h0) // [RULE7]
    else $error("pending clear during transition");
  pending_quiet_a: assert property (fsm == ST_ON || fsm == ST_OFF |-> pending == 2'h0) // [RULE7]
    else $error("pending set outside a transition");
  stop_state_a: assert property (fsm == ST_OFF |-> mod_state == 6'h02 && !PROC_CLK_EN) // [RULE8]
    else $error("module state not disabled after stop");
  gate_step_a: assert property (gate_cause_s |=> gate_done_s) // [RULE15]
    else $error("clock not gated after idle under override");
  gate_cause_a: assert property ($fell(PROC_CLK_EN) |-> $past(idle_q) && $past(override)) // [RULE15]
    else $error("clock gated without idle and override");
  irq_level_a: assert property (##1 INTERRUPT == $past(|(next_irq_stat & next_irq_mask)) || !$past(CE))
    else $error("interrupt output disagrees with status and mask");
endmodule

// ===== verif/proc_sw_model.sv
// processor software stand-in that idles after the power-down interrupt
`timescale 1ns/1ps
module proc_sw_model #(
  parameter int DELAY = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irq,
  input wire logic run,
  output logic idle
);
  int cnt;
  // run low models the routine not yet entered, or the processor woken again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      idle <= 1'b0;
    end else if (!run) begin
      cnt <= 0;
      idle <= 1'b0;
    end else if (irq && cnt < DELAY) begin
      cnt <= cnt + 1; // routine ready, own masters drained, wake source armed
    end else if (cnt == DELAY) begin
      idle <= 1'b1; // idle is the last step of the routine
    end
  end
endmodule

// ===== verif/dsp_clock_stop_sequencer_tb_top.sv
// register level bench for the processor clock stop sequencer
`timescale 1ns/1ps
module dsp_clock_stop_sequencer_tb_top;
  logic clock, reset_n, run, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rd;
  logic [1:0] rsp;
  wire logic idle, awready, wready, bvalid, arready, rvalid, clk_en, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int errors, compares;
  localparam logic [31:0] RA [7] = '{32'h01C4_1010, 32'h01C4_1014, 32'h01C4_1120, 32'h01C4_1128,
    32'h01C4_1800, 32'h01C4_1A00, 32'h01C4_1B00};
  localparam logic [31:0] RV [7] = '{0, 3, 0, 0, 3, 3, 0};

  dsp_clock_stop_sequencer dsp_clock_stop_sequencer_inst (
    .CLOCK(clock), .RESET_N(reset_n), .CE(1'b1), .PROC_IDLE(idle),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PROC_CLK_EN(clk_en), .INTERRUPT(irq)
  );

  proc_sw_model proc_sw_model_inst (.clk(clock), .rst_n(reset_n), .irq(irq), .run(run), .idle(idle));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [31:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // polls a field; the caller compares the last value read
  task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    int n;
    n = 0;
    rdr(a);
    while ((rd & m) !== exp && n < 100) begin
      rdr(a);
      n++;
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    test_done();
  end

  initial begin
    reset_n = 1'b0;
    run = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    check("clk_en at reset", 32'(clk_en), 1);
    check("irq at reset", 32'(irq), 0);
    for (int i = 0; i < 7; i++) begin
      rdr(RA[i]);
      check("reset value", rd, RV[i]);
    end
    rdr(32'h01C4_1004);
    check("unmapped read resp", 32'(rsp), 32'(clkstop_pkg::RESP_SLVERR));
    check("unmapped read data", rd, 0);
    wr(32'h01C4_1FFC, 32'h0000_0001);
    check("unmapped write resp", 32'(rsp), 32'(clkstop_pkg::RESP_SLVERR));
    // host has fenced and drained all masters before this point
    wr(clkstop_pkg::MODULE_CONTROL_ADDR, 32'(clkstop_pkg::NEXT_DISABLE));
    check("disable write resp", 32'(rsp), 32'(clkstop_pkg::RESP_OKAY));
    rdr(clkstop_pkg::IRQ_STATUS_ADDR);
    check("powerdown irq status", rd, 1);
    check("powerdown irq line", 32'(irq), 1);
    wr(clkstop_pkg::IRQ_MASK_ADDR, 0);
    repeat (2) @(posedge clock);
    check("masked irq line", 32'(irq), 0);
    wr(clkstop_pkg::IRQ_MASK_ADDR, 3);
    repeat (2) @(posedge clock);
    check("unmasked irq line", 32'(irq), 1);
    wr(clkstop_pkg::POWER_TRANSITION_COMMAND_ADDR, 32'(clkstop_pkg::GO_START));
    rdr(clkstop_pkg::POWER_TRANSITION_STATUS_ADDR);
    check("pending after go", rd & 3, 32'(clkstop_pkg::PEND_BUSY));
    // the isr writes happen before the processor idles
    wr(clkstop_pkg::PROCESSOR_POWERDOWN_COMMAND_ADDR, 32'h0001_5555);
    rdr(clkstop_pkg::PROCESSOR_POWERDOWN_COMMAND_ADDR);
    check("powerdown command", rd, 32'h0001_5555);
    wr(clkstop_pkg::GLOBAL_POWER_CONTROL_ADDR, 1);
    repeat (20) @(posedge clock);
    check("clk_en before idle", 32'(clk_en), 1);
    rdr(clkstop_pkg::POWER_TRANSITION_STATUS_ADDR);
    check("pending before idle", rd & 3, 1);
    @(posedge clock);
    run <= 1'b1;
    poll(clkstop_pkg::POWER_TRANSITION_STATUS_ADDR, 3, 0);
    check("pending after stop", rd & 3, 0);
    rdr(clkstop_pkg::MODULE_STATUS_ADDR);
    check("state after stop", rd & 32'h3F, 32'(clkstop_pkg::STATE_DISABLED));
    check("clk_en after idle", 32'(clk_en), 0);
    rdr(clkstop_pkg::IRQ_STATUS_ADDR);
    check("irq status after stop", rd, 3);
    // override released only once the stop is reported
    wr(clkstop_pkg::GLOBAL_POWER_CONTROL_ADDR, 0);
    repeat (4) @(posedge clock);
    check("clk_en after release", 32'(clk_en), 0);
    wr(clkstop_pkg::IRQ_STATUS_ADDR, 3);
    rdr(clkstop_pkg::IRQ_STATUS_ADDR);
    check("irq status cleared", rd, 0);
    repeat (2) @(posedge clock);
    check("irq line cleared", 32'(irq), 0);
    @(posedge clock);
    run <= 1'b0;
    wr(clkstop_pkg::MODULE_CONTROL_ADDR, 32'(clkstop_pkg::NEXT_ENABLE));
    wr(clkstop_pkg::POWER_TRANSITION_COMMAND_ADDR, 32'(clkstop_pkg::GO_START));
    poll(clkstop_pkg::POWER_TRANSITION_STATUS_ADDR, 3, 0);
    check("pending after wake", rd & 3, 0);
    rdr(clkstop_pkg::MODULE_STATUS_ADDR);
    check("state after wake", rd & 32'h3F, 32'(clkstop_pkg::STATE_ENABLED));
    check("clk_en after wake", 32'(clk_en), 1);
    test_done();
  end
endmodule
